// *** hdl/sas_adc_sequencer.sv ***
// Purpose: control logic of an 8-bit successive approximation converter
// Assumes: comparator answers on cmp_high for the dac code on dac_code
// Notes:   registers on classic wishbone; one clk domain, ticks are enables
`timescale 1ns/100ps
module sas_adc_sequencer #(
  parameter int CPU_DIV = sas_pkg::CPU_DIV,
  parameter int RC_DIV  = sas_pkg::RC_DIV
) (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst_n,
  // wishbone slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [9:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  // processor modes
  input  wire logic        wait_mode,
  input  wire logic        stop_mode,
  // analog side
  input  wire logic        cmp_high,
  output logic      [7:0]  dac_code,
  output logic      [3:0]  mux_sel,
  output logic             sample_en,
  output logic             analog_power,
  output logic             rc_osc_en,
  // port pins
  input  wire logic [7:0]  port_pins,
  output logic      [7:0]  port_read
);
  logic [7:0]          ctrl_reg;
  logic                done_reg;
  logic [7:0]          result_reg;
  logic [7:0]          sar_reg;
  logic [4:0]          cyc_reg;
  logic [2:0]          bit_reg;
  logic [7:0]          div_reg;
  logic                tick;
  logic                cmp_s1_reg, cmp_s2_reg;
  logic                stop_s1_reg, stop_s2_reg;
  logic [7:0]          pin_s1_reg, pin_s2_reg;
  sas_pkg::sas_state_e state_reg;
  logic                req, wr_ctrl, rd_result, finish;
  logic                result_load;
  logic [3:0]          chan;
  logic                pwr, rc;

  assign chan = ctrl_reg[sas_pkg::CH_MSB:0];
  assign pwr  = ctrl_reg[sas_pkg::BIT_PWR];
  assign rc   = ctrl_reg[sas_pkg::BIT_RC];
  assign req  = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign wr_ctrl   = req && wb_we_i && wb_sel_i[0]
                     && (wb_adr_i == {sas_pkg::IDX_CTRL, 2'b00});
  assign rd_result = req && !wb_we_i && (wb_adr_i == {sas_pkg::IDX_RESULT, 2'b00});

  // synchronisers: pins and comparator are asynchronous
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cmp_s1_reg  <= 1'b0;
      cmp_s2_reg  <= 1'b0;
      stop_s1_reg <= 1'b0;
      stop_s2_reg <= 1'b0;
      pin_s1_reg  <= 8'h00;
      pin_s2_reg  <= 8'h00;
    end else begin
      cmp_s1_reg  <= cmp_high;
      cmp_s2_reg  <= cmp_s1_reg;
      stop_s1_reg <= stop_mode;
      stop_s2_reg <= stop_s1_reg;
      pin_s1_reg  <= port_pins;
      pin_s2_reg  <= pin_s1_reg;
    end
  end

  // conversion clock as an enable; rc tick is modelled by its own divide
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      div_reg <= 8'h00;
      tick    <= 1'b0;
    end else if (!pwr || stop_s2_reg || wr_ctrl) begin
      div_reg <= 8'h00;
      tick    <= 1'b0;
    end else if (div_reg == (rc ? 8'(RC_DIV - 1) : 8'(CPU_DIV - 1))) begin
      div_reg <= 8'h00;
      tick    <= 1'b1;
    end else begin
      div_reg <= div_reg + 8'h01;
      tick    <= 1'b0;
    end
  end

  // wait mode is not looked at: conversion carries on regardless
  assign finish = tick && (state_reg == sas_pkg::SAS_RESOLV)
                  && (cyc_reg == 5'(sas_pkg::CONV_CYCLES - 1));
  // a finishing result is dropped when a write restarts in the same cycle
  assign result_load = finish && pwr && !stop_s2_reg && !wr_ctrl;

  // control register
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_reg <= 8'h00;
    end else if (wr_ctrl) begin
      ctrl_reg <= {1'b0, wb_dat_i[6:5], 1'b0, wb_dat_i[3:0]};
    end
  end

  // sequencer: sample, then one decision per bit
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= sas_pkg::SAS_IDLE;
      cyc_reg   <= 5'h00;
      bit_reg   <= 3'h7;
      sar_reg   <= 8'h00;
    end else if (!pwr || stop_s2_reg) begin
      state_reg <= sas_pkg::SAS_IDLE;
    end else if (wr_ctrl) begin
      state_reg <= sas_pkg::SAS_SAMPLE;
      cyc_reg   <= 5'h00;
      bit_reg   <= 3'h7;
      sar_reg   <= sas_pkg::CODE_MID;
    end else if (tick) begin
      case (state_reg)
        sas_pkg::SAS_IDLE: begin
          state_reg <= sas_pkg::SAS_SAMPLE;
          cyc_reg   <= 5'h00;
          sar_reg   <= sas_pkg::CODE_MID;
          bit_reg   <= 3'h7;
        end
        sas_pkg::SAS_SAMPLE: begin
          cyc_reg <= cyc_reg + 5'h01;
          if (cyc_reg == 5'(sas_pkg::SAMPLE_CYC - 1))
            state_reg <= sas_pkg::SAS_RESOLV;
        end
        sas_pkg::SAS_RESOLV: begin
          if (finish) begin
            state_reg <= sas_pkg::SAS_SAMPLE;
            cyc_reg   <= 5'h00;
            sar_reg   <= sas_pkg::CODE_MID;
            bit_reg   <= 3'h7;
          end else begin
            cyc_reg <= cyc_reg + 5'h01;
            // decide one bit every other tick, settling time for the dac
            if (cyc_reg[0] && (cyc_reg < 5'(sas_pkg::SAMPLE_CYC + 16))) begin
              sar_reg[bit_reg] <= cmp_s2_reg;
              if (bit_reg != 3'h0) begin
                sar_reg[bit_reg - 3'h1] <= 1'b1;
                bit_reg <= bit_reg - 3'h1;
              end
            end
          end
        end
        default: state_reg <= sas_pkg::SAS_IDLE;
      endcase
    end
  end

  // result and flag; result loads in bus clock domain only
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      result_reg <= 8'h00;
    end else if (finish && pwr && !stop_s2_reg && !wr_ctrl) begin
      result_reg <= (chan == sas_pkg::CH_TEST) ? sas_pkg::CODE_ZERO : sar_reg;
    end
  end

  // set wins over the read-clear
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      done_reg <= 1'b0;
    end else if (finish && pwr && !stop_s2_reg && !wr_ctrl) begin
      done_reg <= 1'b1;
    end else if (wr_ctrl || rd_result) begin
      done_reg <= 1'b0;
    end
  end

  // bus answer, one cycle after the request
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= req;
      wb_dat_o <= 32'h0000_0000;
      if (req && !wb_we_i) begin
        if (wb_adr_i == {sas_pkg::IDX_RESULT, 2'b00})
          wb_dat_o <= {24'h00_0000, result_reg};
        else if (wb_adr_i == {sas_pkg::IDX_CTRL, 2'b00})
          wb_dat_o <= {24'h00_0000, done_reg, ctrl_reg[6:0]};
      end
    end
  end

  // analog outputs and pin masking
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      dac_code     <= 8'h00;
      mux_sel      <= 4'h0;
      sample_en    <= 1'b0;
      analog_power <= 1'b0;
      rc_osc_en    <= 1'b0;
      port_read    <= 8'h00;
    end else begin
      dac_code     <= sar_reg;
      mux_sel      <= chan;
      sample_en    <= pwr && (state_reg == sas_pkg::SAS_SAMPLE);
      analog_power <= pwr && !stop_s2_reg;
      rc_osc_en    <= pwr && rc && !stop_s2_reg;
      port_read    <= pin_s2_reg;
      if (pwr && !chan[3])
        port_read[chan[2:0]] <= 1'b0;
    end
  end

  // checks: flag and result
  a_flag_sets: assert property (@(posedge clk) disable iff (!rst_n)
    result_load |=> done_reg)
    else $error("flag not set after finish");
  a_write_clears: assert property (@(posedge clk) disable iff (!rst_n)
    (wr_ctrl && !finish) |=> !done_reg)
    else $error("control write left flag set");
  a_read_clears: assert property (@(posedge clk) disable iff (!rst_n)
    (rd_result && !finish) |=> !done_reg)
    else $error("result read left flag set");
  a_done_hold: assert property (@(posedge clk) disable iff (!rst_n)
    (!finish && !wr_ctrl && !rd_result) |=> $stable(done_reg))
    else $error("flag moved with no cause");
  a_test_zero: assert property (@(posedge clk) disable iff (!rst_n)
    (result_load && chan == sas_pkg::CH_TEST) |=> result_reg == sas_pkg::CODE_ZERO)
    else $error("test channel not zero");
  a_result_load: assert property (@(posedge clk) disable iff (!rst_n)
    (result_load && chan != sas_pkg::CH_TEST) |=> result_reg == $past(sar_reg))
    else $error("result not loaded");
  a_result_hold: assert property (@(posedge clk) disable iff (!rst_n)
    !result_load |=> $stable(result_reg))
    else $error("result changed without a finish");
  a_read_data: assert property (@(posedge clk) disable iff (!rst_n)
    (req && !wb_we_i && wb_adr_i == {sas_pkg::IDX_RESULT, 2'b00})
    |=> wb_dat_o == {24'h00_0000, $past(result_reg)})
    else $error("result read data wrong");

  // checks: control register and bus
  a_ctrl_layout: assert property (@(posedge clk) disable iff (!rst_n)
    wr_ctrl |=> ctrl_reg == {1'b0, $past(wb_dat_i[6:5]), 1'b0, $past(wb_dat_i[3:0])})
    else $error("control write layout wrong");
  a_ctrl_spare: assert property (@(posedge clk) disable iff (!rst_n)
    !ctrl_reg[sas_pkg::BIT_DONE] && !ctrl_reg[sas_pkg::CH_MSB + 1])
    else $error("spare control bit set");
  a_ctrl_read: assert property (@(posedge clk) disable iff (!rst_n)
    (req && !wb_we_i && wb_adr_i == {sas_pkg::IDX_CTRL, 2'b00})
    |=> wb_dat_o == {24'h00_0000, $past(done_reg), $past(ctrl_reg[6:0])})
    else $error("control read data wrong");
  a_unmapped_read: assert property (@(posedge clk) disable iff (!rst_n)
    (req && !wb_we_i && wb_adr_i != {sas_pkg::IDX_CTRL, 2'b00}
     && wb_adr_i != {sas_pkg::IDX_RESULT, 2'b00}) |=> wb_dat_o == 32'h0000_0000)
    else $error("unmapped read not zero");
  a_ack_pulse: assert property (@(posedge clk) disable iff (!rst_n)
    wb_ack_o |=> !wb_ack_o)
    else $error("ack held two cycles");
  a_ack_answer: assert property (@(posedge clk) disable iff (!rst_n)
    req |=> wb_ack_o)
    else $error("request not acknowledged");
  a_ack_cause: assert property (@(posedge clk) disable iff (!rst_n)
    wb_ack_o |-> $past(req))
    else $error("ack without request");
  a_ack_idle: assert property (@(posedge clk) disable iff (!rst_n)
    !wb_cyc_i |=> !wb_ack_o)
    else $error("ack outside a cycle");
  a_dat_quiet: assert property (@(posedge clk) disable iff (!rst_n)
    !wb_ack_o |-> wb_dat_o == 32'h0000_0000)
    else $error("read data outside ack");

  // checks: sequencer
  a_restart: assert property (@(posedge clk) disable iff (!rst_n)
    (wr_ctrl && pwr && !stop_s2_reg) |=> state_reg == sas_pkg::SAS_SAMPLE
    && cyc_reg == 5'h00 && sar_reg == sas_pkg::CODE_MID)
    else $error("control write did not restart");
  a_sample_len: assert property (@(posedge clk) disable iff (!rst_n)
    (tick && pwr && !stop_s2_reg && !wr_ctrl && state_reg == sas_pkg::SAS_SAMPLE
     && cyc_reg == 5'(sas_pkg::SAMPLE_CYC - 1)) |=> state_reg == sas_pkg::SAS_RESOLV)
    else $error("sample phase length wrong");
  a_sample_range: assert property (@(posedge clk) disable iff (!rst_n)
    state_reg == sas_pkg::SAS_SAMPLE |-> cyc_reg < 5'(sas_pkg::SAMPLE_CYC))
    else $error("sample count out of range");
  a_resolve_range: assert property (@(posedge clk) disable iff (!rst_n)
    state_reg == sas_pkg::SAS_RESOLV |-> cyc_reg >= 5'(sas_pkg::SAMPLE_CYC))
    else $error("resolve count out of range");
  a_sample_code: assert property (@(posedge clk) disable iff (!rst_n)
    state_reg == sas_pkg::SAS_SAMPLE |-> sar_reg == sas_pkg::CODE_MID && bit_reg == 3'h7)
    else $error("trial code not reset for sample");
  a_bits_used: assert property (@(posedge clk) disable iff (!rst_n)
    (state_reg == sas_pkg::SAS_RESOLV && cyc_reg >= 5'(sas_pkg::SAMPLE_CYC + 16))
    |-> bit_reg == 3'h0)
    else $error("bits left undecided");
  a_finish_loop: assert property (@(posedge clk) disable iff (!rst_n)
    result_load |=> state_reg == sas_pkg::SAS_SAMPLE && cyc_reg == 5'h00)
    else $error("conversion did not repeat");
  a_dac_follow: assert property (@(posedge clk) disable iff (!rst_n)
    1'b1 |=> dac_code == $past(sar_reg))
    else $error("dac code lags trial code");

  // checks: conversion clock
  a_tick_pulse: assert property (@(posedge clk) disable iff (!rst_n)
    tick |=> !tick)
    else $error("tick wider than one cycle");
  a_tick_phase: assert property (@(posedge clk) disable iff (!rst_n)
    tick |-> div_reg == 8'h00)
    else $error("tick off divider wrap");
  a_cpu_div: assert property (@(posedge clk) disable iff (!rst_n)
    !rc |-> div_reg < 8'(CPU_DIV))
    else $error("cpu divider overran");
  a_rc_div: assert property (@(posedge clk) disable iff (!rst_n)
    rc |-> div_reg < 8'(RC_DIV))
    else $error("rc divider overran");
  a_off_quiet: assert property (@(posedge clk) disable iff (!rst_n)
    !pwr |=> !tick && div_reg == 8'h00)
    else $error("divider runs while off");

  // checks: power, stop and pins
  a_power_off: assert property (@(posedge clk) disable iff (!rst_n)
    !pwr |=> state_reg == sas_pkg::SAS_IDLE && !rc_osc_en)
    else $error("converter runs while off");
  a_power_pin: assert property (@(posedge clk) disable iff (!rst_n)
    (pwr && !stop_s2_reg) |=> analog_power)
    else $error("analog power missing");
  a_rc_enable: assert property (@(posedge clk) disable iff (!rst_n)
    (pwr && rc && !stop_s2_reg) |=> rc_osc_en)
    else $error("rc oscillator not enabled");
  a_stop_abort: assert property (@(posedge clk) disable iff (!rst_n)
    stop_s2_reg |=> state_reg == sas_pkg::SAS_IDLE)
    else $error("stop did not abort");
  a_stop_quiet: assert property (@(posedge clk) disable iff (!rst_n)
    stop_s2_reg |=> !tick && !analog_power && !rc_osc_en)
    else $error("converter powered in stop");
  a_sample_out: assert property (@(posedge clk) disable iff (!rst_n)
    (pwr && state_reg == sas_pkg::SAS_SAMPLE) |=> sample_en)
    else $error("sample enable missing");
  a_mux_follow: assert property (@(posedge clk) disable iff (!rst_n)
    1'b1 |=> mux_sel == $past(chan))
    else $error("mux select not channel field");
  a_pin_mask: assert property (@(posedge clk) disable iff (!rst_n)
    (pwr && !chan[3] && !wr_ctrl) |=> port_read[$past(chan[2:0])] == 1'b0)
    else $error("selected pin not masked");
  a_pins_free: assert property (@(posedge clk) disable iff (!rst_n)
    (!pwr || chan[3]) |=> port_read == $past(pin_s2_reg))
    else $error("pins masked while free");
endmodule : sas_adc_sequencer

// *** hdl/sas_pkg.sv ***
// Purpose: constants shared by the converter sequencer
// Assumes: byte offsets on a 32-bit classic wishbone bus
// Notes:   register index times four gives the byte address
package sas_pkg;
  localparam logic [7:0] IDX_RESULT   = 8'h3A;
  localparam logic [7:0] IDX_CTRL     = 8'h3B;
  localparam int         BIT_DONE     = 7;
  localparam int         BIT_RC       = 6;
  localparam int         BIT_PWR      = 5;
  localparam int         CH_MSB       = 3;
  localparam int         CONV_CYCLES  = 32;
  localparam int         SAMPLE_CYC   = 12;
  localparam logic [7:0] CODE_FULL    = 8'hFF;
  localparam logic [7:0] CODE_ZERO    = 8'h00;
  localparam logic [7:0] CODE_MID     = 8'h80;
  localparam logic [3:0] CH_REFH      = 4'hC;
  localparam logic [3:0] CH_MIDREF    = 4'hD;
  localparam logic [3:0] CH_REFL      = 4'hE;
  localparam logic [3:0] CH_TEST      = 4'hF;
  localparam int         CPU_DIV      = 125;
  localparam int         RC_DIV       = 167;
  typedef enum logic [1:0] {
    SAS_IDLE   = 2'b00,
    SAS_SAMPLE = 2'b01,
    SAS_RESOLV = 2'b11
  } sas_state_e;
endpackage : sas_pkg

// *** sim/sas_analog_model.sv ***
// Purpose: analog front end seen by the converter sequencer
// Assumes: a held level v compares high while dac_code is not above v
// Notes:   the held sample keeps later pin moves out of a running conversion
`timescale 1ns/100ps
module sas_analog_model (
  // analog side
  input  wire logic            clk,
  input  wire logic [7:0]      dac_code,
  input  wire logic [3:0]      mux_sel,
  input  wire logic            sample_en,
  input  wire logic            analog_power,
  // pin levels from the bench
  input  wire logic [7:0][7:0] pin_level,
  output logic                 cmp_high
);
  logic [7:0] held_reg;
  logic [7:0] live;
  logic       wander_reg = 1'b0;
  always_comb begin
    case (mux_sel)
      4'hC:    live = 8'hFF;
      4'hD:    live = 8'h80;
      4'hE:    live = 8'h00;
      4'hF:    live = 8'hA5;
      default: live = mux_sel[3] ? 8'h5A : pin_level[mux_sel[2:0]];
    endcase
  end
  always_ff @(posedge clk) begin
    if (sample_en) begin
      held_reg <= live;
    end
  end
  // unpowered output wanders so a stale level is never trusted
  always_ff @(posedge clk) begin
    wander_reg <= ~wander_reg;
  end
  assign cmp_high = analog_power ? (held_reg >= dac_code) : wander_reg;
endmodule : sas_analog_model

// *** sim/sas_adc_sequencer_bench.sv ***
// Purpose: self-checking bench for the converter sequencer
// Assumes: tick dividers shortened to 2 and 3 clocks
// Notes:   channel rows first, then timing, overwrite, power, stop, reset
`timescale 1ns/100ps
module sas_adc_sequencer_bench;
  typedef struct {logic [7:0] ctl; logic [7:0] res; logic [7:0] prd;} sas_row_s;
  // cpu tick kept faster than rc tick; rc also runs in the odd rows and while settling after power up
  localparam int CD = 2;
  localparam int RC_SETTLE  = 1250;
  localparam int PWR_SETTLE = 25000;
  localparam int RD = 3;
  logic clk, rst_n, cyc, stb, we, ack, cmp, smp, pwr, rce, wm, sm;
  logic [9:0]      adr;
  logic [3:0]      mux;
  logic [31:0]     wd, rdat, q;
  logic [7:0]      dac, pins, prd;
  logic [7:0][7:0] lvl;
  int errors, tests_run, n, h;
  sas_row_s rows [8] = '{'{8'hB0, 8'h11, 8'hFE}, '{8'h63, 8'h44, 8'hF7},
    '{8'h27, 8'h88, 8'h7F}, '{8'h68, 8'h5A, 8'hFF}, '{8'h2C, 8'hFF, 8'hFF},
    '{8'h6D, 8'h80, 8'hFF}, '{8'h2E, 8'h00, 8'hFF}, '{8'h6F, 8'h00, 8'hFF}};
  sas_adc_sequencer #(.CPU_DIV(CD), .RC_DIV(RD)) sas_adc_sequencer_inst (.clk(clk),
    .rst_n(rst_n), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(4'h1), .wb_dat_i(wd), .wb_dat_o(rdat), .wb_ack_o(ack), .wait_mode(wm),
    .stop_mode(sm), .cmp_high(cmp), .dac_code(dac), .mux_sel(mux), .sample_en(smp),
    .analog_power(pwr), .rc_osc_en(rce), .port_pins(pins), .port_read(prd));
  sas_analog_model sas_analog_model_inst (.clk(clk), .dac_code(dac), .mux_sel(mux),
    .sample_en(smp), .analog_power(pwr), .pin_level(lvl), .cmp_high(cmp));
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  task automatic check(string what, logic [31:0] exp, logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      errors++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask : check
  task automatic end_of_test();
    $display("errors %0d tests_run %0d", errors, tests_run);
    if (errors == 0 && tests_run > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : end_of_test
  task automatic bail();
    errors++;
    end_of_test();
  endtask : bail
  // request held until ack is seen at an edge, then one idle edge
  task automatic wb(logic w, logic [9:0] a, logic [31:0] d);
    int k;
    k = 0;
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wd <= d;
    do begin
      @(posedge clk);
      k++;
    end while (ack !== 1'b1 && k < 50);
    if (ack !== 1'b1) bail();
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk);
  endtask : wb
  task automatic wait_done();
    q = '0;
    n = 0;
    while (q[7] !== 1'b1 && n < 300) begin wb(0, 10'h0EC, 0); n++; end
    if (n >= 300) bail();
  endtask : wait_done
  task automatic period(int div);
    n = 0;
    while (smp === 1'b1 && n < 500) begin @(posedge clk); n++; end
    while (smp !== 1'b1 && n < 500) begin @(posedge clk); n++; end
    n = 0;
    while (smp === 1'b1 && n < 500) begin @(posedge clk); n++; end
    h = n;
    while (smp !== 1'b1 && n < 500) begin @(posedge clk); n++; end
    if (n >= 500) bail();
    check("sample_len", 12 * div, h);
    check("period", 32 * div, n);
  endtask : period
  initial begin
    rst_n = 0; cyc = 0; stb = 0; we = 0; adr = '0; wd = '0;
    wm = 0; sm = 0; pins = 8'hFF; errors = 0; tests_run = 0;
    for (int i = 0; i < 8; i++) lvl[i] = 8'h11 * (i + 1);
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    wb(0, 10'h0EC, 0); check("ctrl_reset", 0, q);
    check("power_reset", 0, pwr);
    wb(0, 10'h100, 0); check("unmapped", 0, q);
    wb(1, 10'h0EC, 8'h60);
    repeat (RC_SETTLE) @(posedge clk);
    repeat (PWR_SETTLE - RC_SETTLE) @(posedge clk);
    foreach (rows[i]) begin
      wm <= i[0];
      wb(1, 10'h0EC, rows[i].ctl);
      wb(0, 10'h0EC, 0); check("ctrl_back", rows[i].ctl & 8'h6F, q);
      check("rc_osc", rows[i].ctl[6], rce);
      check("mux", rows[i].ctl[3:0], mux);
      wait_done();
      check("dac_mid", sas_pkg::CODE_MID, dac);
      wb(0, 10'h0E8, 0); check("result", rows[i].res, q);
      wb(0, 10'h0EC, 0); check("flag_clear", 0, q[7]);
      check("port_read", rows[i].prd, prd);
    end
    wb(1, 10'h0EC, 8'h21);
    period(CD);
    wb(1, 10'h0EC, 8'h61);
    period(RD);
    wb(1, 10'h0EC, 8'h22);
    wait_done();
    lvl[2] <= 8'h3C;
    repeat (2 * 32 * CD + 8) @(posedge clk);
    wb(0, 10'h0E8, 0); check("overwrite", 8'h3C, q);
    wb(1, 10'h0EC, 8'h43);
    repeat (4) @(posedge clk);
    check("pwr_off", 0, {pwr, rce});
    check("pins_free", 8'hFF, prd);
    wb(1, 10'h0EC, 8'h21);
    sm <= 1'b1;
    repeat (6) @(posedge clk);
    h = 0;
    repeat (100) begin @(posedge clk); h += smp; end
    check("stop_idle", 0, {pwr, h[30:0]});
    sm <= 1'b0;
    wait_done();
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    check("out_rereset", 0, {pwr, rce, smp});
    wb(0, 10'h0EC, 0); check("ctrl_rereset", 0, q);
    end_of_test();
  end
endmodule : sas_adc_sequencer_bench
